// ---- src/tmo_timer.sv ----
//------------------------------------------------------------------------
// Behaviour
// - Oscillator amplifier on only while enabled
// - Oscillator keeps running in every power mode
// - Select 01 enters secondary run mode
// - Sleep, idle bit clear: secondary idle from secondary run, primary idle from primary run
// - Active flag tracks secondary clock, cleared on failure
// - Counter counts 0000h to FFFFh, wraps
// - Wrap sets flag; interrupt gated by enable
// - Special-event compare match clears counter
// - Unit B trigger starts converter if enabled and not counting unsynchronised
// - Trigger clear skipped in unsynchronised counting
// - Compare value acts as counter period
// - Software counter write beats trigger clear
// - Trigger never sets overflow flag
// - Source bit: instruction cycle or input edge
// - Oscillator enabled: pin digital paths read zero
//------------------------------------------------------------------------
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module tmo_timer
    import tmo_pkg::*;
(
    input  wire logic                     I_CLOCK,       // 125 MHz clock
    input  wire logic                     I_RESET_N,     // Async reset
    input  wire logic                     I_PSEL,        // APB select
    input  wire logic                     I_PENABLE,     // APB enable
    input  wire logic                     I_PWRITE,      // APB direction
    input  wire logic [tmo_pkg::ADDR_W-1:0] I_PADDR,     // APB address
    input  wire logic [31:0]              I_PWDATA,      // APB write data
    input  wire logic [3:0]               I_PSTRB,       // APB byte lanes
    output logic      [31:0]              O_PRDATA,      // APB read data
    output logic                          O_PREADY,      // APB ready
    output logic                          O_PSLVERR,     // APB error
    input  wire logic                     I_OSC_IN_PIN,  // Osc input pin
    input  wire logic                     I_OSC_OUT_PIN, // Osc output pin
    input  wire logic                     I_OSC_FAIL,    // Clock monitor
    input  wire logic                     I_SLEEP_EXEC,  // Sleep executed
    input  wire logic                     I_WAKE,        // Wake event
    output logic                          O_OSC_EN,      // Amplifier on
    output logic                          O_PIN_DIG_DIS, // Pin I/O off
    output logic      [1:0]               O_PIN_RD,      // Pin read value
    output logic                          O_IRQ,         // Overflow irq
    output logic                          O_ADC_START,   // Start pulse
    output logic                          O_SEC_ACTIVE,  // Sec clock flag
    output logic      [2:0]               O_PM_MODE      // Power mode
);

    //------------------------------------------------------------------
    // Reset release
    //------------------------------------------------------------------
    logic [1:0] rst_q;
    logic       rst_n;

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    //------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------
    tmo_pin_if pins ();

    tmo_pin_sync u_sync (
        .i_clk   (I_CLOCK),
        .i_rst_n (rst_n),
        .i_raw   ({I_OSC_FAIL, I_OSC_OUT_PIN, I_OSC_IN_PIN}),
        .pins    (pins.src)
    );

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    logic        on_q, src_q, nosync_q, oscen_q;
    logic [15:0] count_q;
    logic        ovf_q, irqen_q, idle_q, adc_en_q;
    logic [1:0]  sel_q;
    logic [15:0] cmp_val_q  [2];
    logic [3:0]  cmp_mode_q [2];
    logic [1:0]  cmp_use_q;
    logic [1:0]  match_q;
    logic [1:0]  trig;
    logic [1:0]  match_now;
    logic        trig_clr;
    tmo_pm_e     pm_q;
    logic        active_q;
    logic [1:0]  div_q;
    logic        pready_q, pslverr_q;
    logic [31:0] prdata_q, rd_d;
    logic        mapped;
    logic        acc, done, wr, wr0;
    logic        instr_tick, cnt_tick, ovf_set, wr_count;

    //------------------------------------------------------------------
    // APB slave, one wait state
    //------------------------------------------------------------------
    assign acc  = I_PSEL & I_PENABLE;
    assign done = acc & pready_q;
    assign wr   = done & I_PWRITE;
    assign wr0  = wr & I_PSTRB[0];

    always_comb begin
        rd_d   = 32'h0000_0000;
        mapped = 1'b1;
        case (I_PADDR)
            OFS_CTRL: begin
                rd_d[CTL_ON]     = on_q;
                rd_d[CTL_SRC]    = src_q;
                rd_d[CTL_NOSYNC] = nosync_q;
                rd_d[CTL_OSCEN]  = oscen_q;
                rd_d[CTL_ACTIVE] = active_q;
            end
            OFS_COUNT: rd_d[15:0] = count_q;
            OFS_FLAG:  rd_d[0]    = ovf_q;
            OFS_IRQEN: rd_d[0]    = irqen_q;
            OFS_OSC: begin
                rd_d[OSC_SEL +: 2]  = sel_q;
                rd_d[OSC_IDLE]      = idle_q;
                rd_d[OSC_MODE +: 3] = pm_q;
            end
            OFS_CMPA, OFS_CMPB: begin
                rd_d[CMP_VAL +: 16] = cmp_val_q[I_PADDR == OFS_CMPB];
                rd_d[CMP_MODE +: 4] = cmp_mode_q[I_PADDR == OFS_CMPB];
                rd_d[CMP_USE]       = cmp_use_q[I_PADDR == OFS_CMPB];
            end
            OFS_ADC:   rd_d[0] = adc_en_q;
            default:   mapped  = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q <= acc & ~pready_q;
            if (acc & ~pready_q) begin
                pslverr_q <= ~mapped;
                prdata_q  <= (I_PWRITE | ~mapped) ? 32'h0000_0000 : rd_d;
            end else begin
                pslverr_q <= 1'b0;
                prdata_q  <= 32'h0000_0000;
            end
        end
    end

    assign O_PREADY  = pready_q;
    assign O_PSLVERR = pslverr_q;
    assign O_PRDATA  = prdata_q;

    //------------------------------------------------------------------
    // Control registers
    //------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            on_q     <= 1'b0;
            src_q    <= 1'b0;
            nosync_q <= 1'b0;
            oscen_q  <= 1'b0;
            irqen_q  <= 1'b0;
            sel_q    <= SEL_RST;
            idle_q   <= 1'b0;
            adc_en_q <= 1'b0;
        end else if (wr0) begin
            case (I_PADDR)
                OFS_CTRL: begin
                    on_q     <= I_PWDATA[CTL_ON];
                    src_q    <= I_PWDATA[CTL_SRC];
                    nosync_q <= I_PWDATA[CTL_NOSYNC];
                    oscen_q  <= I_PWDATA[CTL_OSCEN];
                end
                OFS_IRQEN: irqen_q  <= I_PWDATA[0];
                OFS_OSC: begin
                    sel_q  <= I_PWDATA[OSC_SEL +: 2];
                    idle_q <= I_PWDATA[OSC_IDLE];
                end
                OFS_ADC:   adc_en_q <= I_PWDATA[0];
                default:   ;
            endcase
        end
    end

    //------------------------------------------------------------------
    // Compare units
    //------------------------------------------------------------------
    genvar u;
    generate
        for (u = 0; u < 2; u++) begin : g_cmp
            localparam logic [7:0] OFS = (u == 0) ? OFS_CMPA : OFS_CMPB;
            always_ff @(posedge I_CLOCK or negedge rst_n) begin
                if (!rst_n) begin
                    cmp_val_q[u]  <= CMP_RST;
                    cmp_mode_q[u] <= CMP_MODE_RST;
                    cmp_use_q[u]  <= 1'b0;
                end else if (wr && I_PADDR == OFS) begin
                    if (I_PSTRB[0]) begin
                        cmp_val_q[u][7:0] <= I_PWDATA[CMP_VAL +: 8];
                    end
                    if (I_PSTRB[1]) begin
                        cmp_val_q[u][15:8] <= I_PWDATA[CMP_VAL+8 +: 8];
                    end
                    if (I_PSTRB[2]) begin
                        cmp_mode_q[u] <= I_PWDATA[CMP_MODE +: 4];
                        cmp_use_q[u]  <= I_PWDATA[CMP_USE];
                    end
                end
            end
            assign match_now[u] = cmp_use_q[u]
                                & (cmp_mode_q[u] == MODE_SPECIAL)
                                & (count_q == cmp_val_q[u]);
            assign trig[u] = match_now[u] & ~match_q[u];
        end
    endgenerate

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            match_q <= 2'b00;
        end else begin
            match_q <= match_now;
        end
    end

    assign trig_clr = (|trig) & ~(src_q & nosync_q);

    //------------------------------------------------------------------
    // Instruction-cycle divider
    //------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 2'b00;
        end else begin
            div_q <= div_q + 2'b01;
        end
    end

    assign instr_tick = (div_q == INSTR_DIV_M1) & (pm_q != PM_SLEEP);
    assign cnt_tick   = on_q & (src_q
                      ? pins.in_rise & (nosync_q | (pm_q != PM_SLEEP))
                      : instr_tick);

    //------------------------------------------------------------------
    // Counter
    //------------------------------------------------------------------
    assign wr_count = wr && I_PADDR == OFS_COUNT && (|I_PSTRB[1:0]);
    // only a counting wrap sets the flag
    assign ovf_set  = cnt_tick & (count_q == COUNT_MAX)
                    & ~wr_count & ~trig_clr;

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= COUNT_RST;
        end else if (wr_count) begin
            if (I_PSTRB[0]) begin
                count_q[7:0] <= I_PWDATA[7:0];
            end
            if (I_PSTRB[1]) begin
                count_q[15:8] <= I_PWDATA[15:8];
            end
        end else if (trig_clr) begin
            count_q <= COUNT_RST;
        end else if (cnt_tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    //------------------------------------------------------------------
    // Overflow flag and interrupt
    //------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (wr0 && I_PADDR == OFS_FLAG && I_PWDATA[0]) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_IRQ       <= 1'b0;
            O_ADC_START <= 1'b0;
        end else begin
            O_IRQ       <= ovf_q & irqen_q;
            O_ADC_START <= trig[1] & ~(src_q & nosync_q) & adc_en_q;
        end
    end

    //------------------------------------------------------------------
    // Oscillator and pins
    //------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_OSC_EN      <= 1'b0;
            O_PIN_DIG_DIS <= 1'b0;
            O_PIN_RD      <= 2'b00;
        end else begin
            O_OSC_EN      <= oscen_q;
            O_PIN_DIG_DIS <= oscen_q;
            O_PIN_RD      <= oscen_q ? 2'b00 : pins.lvl[1:0];
        end
    end

    //------------------------------------------------------------------
    // Power-managed modes
    //------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            pm_q <= PM_PRI_RUN;
        end else begin
            case (pm_q)
                PM_PRI_RUN, PM_SEC_RUN: begin
                    if (pm_q == PM_SEC_RUN && pins.lvl[2]) begin
                        pm_q <= PM_PRI_RUN;
                    end else if (I_SLEEP_EXEC) begin
                        if (!idle_q) begin
                            pm_q <= (pm_q == PM_SEC_RUN) ? PM_SEC_IDLE
                                                         : PM_PRI_IDLE;
                        end else begin
                            pm_q <= PM_SLEEP;
                        end
                    end else if (sel_q == SEL_SECONDARY && !pins.lvl[2]) begin
                        pm_q <= PM_SEC_RUN;
                    end else begin
                        pm_q <= PM_PRI_RUN;
                    end
                end
                PM_SEC_IDLE: begin
                    if (pins.lvl[2]) begin
                        pm_q <= PM_PRI_IDLE;
                    end else if (I_WAKE) begin
                        pm_q <= PM_SEC_RUN;
                    end
                end
                PM_PRI_IDLE, PM_SLEEP: begin
                    if (I_WAKE) begin
                        pm_q <= PM_PRI_RUN;
                    end
                end
                default: pm_q <= PM_PRI_RUN;
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else begin
            active_q <= (pm_q == PM_SEC_RUN) | (pm_q == PM_SEC_IDLE);
        end
    end

    assign O_SEC_ACTIVE = active_q;
    assign O_PM_MODE    = pm_q;

endmodule

`default_nettype wire

// ---- src/tmo_pkg.sv ----
`default_nettype none

package tmo_pkg;

    //------------------------------------------------------------------
    // Register map
    //------------------------------------------------------------------
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_COUNT  = 8'h04;
    localparam logic [7:0]  OFS_FLAG   = 8'h08;
    localparam logic [7:0]  OFS_IRQEN  = 8'h0C;
    localparam logic [7:0]  OFS_OSC    = 8'h10;
    localparam logic [7:0]  OFS_CMPA   = 8'h14;
    localparam logic [7:0]  OFS_CMPB   = 8'h18;
    localparam logic [7:0]  OFS_ADC    = 8'h1C;

    //------------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------------
    localparam int          CTL_ON     = 0;
    localparam int          CTL_SRC    = 1;
    localparam int          CTL_NOSYNC = 2;
    localparam int          CTL_OSCEN  = 3;
    localparam int          CTL_ACTIVE = 6;
    localparam int          CMP_VAL    = 0;
    localparam int          CMP_MODE   = 16;
    localparam int          CMP_USE    = 20;
    localparam int          OSC_SEL    = 0;
    localparam int          OSC_IDLE   = 2;
    localparam int          OSC_MODE   = 4;

    //------------------------------------------------------------------
    // Values and counts
    //------------------------------------------------------------------
    localparam logic [3:0]  MODE_SPECIAL  = 4'hB;
    localparam logic [1:0]  SEL_SECONDARY = 2'h1;
    localparam logic [1:0]  SEL_RST       = 2'h0;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [15:0] CMP_RST       = 16'h0000;
    localparam logic [3:0]  CMP_MODE_RST  = 4'h0;
    localparam logic [1:0]  INSTR_DIV_M1  = 2'h3;

    typedef enum logic [2:0] {
        PM_PRI_RUN  = 3'b000,
        PM_SEC_RUN  = 3'b001,
        PM_PRI_IDLE = 3'b010,
        PM_SEC_IDLE = 3'b011,
        PM_SLEEP    = 3'b100
    } tmo_pm_e;

endpackage

`default_nettype wire

// ---- src/tmo_pin_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface tmo_pin_if;
    logic [2:0] lvl;
    logic       in_rise;
    modport src (output lvl, output in_rise);
    modport snk (input lvl, input in_rise);
endinterface

`default_nettype wire

// ---- src/tmo_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module tmo_pin_sync (
    input  wire logic       i_clk,   // System clock
    input  wire logic       i_rst_n, // Synchronised reset, low active
    input  wire logic [2:0] i_raw,   // Raw pins: in, out, fail
    tmo_pin_if.src          pins     // Synchronised levels and edge
);
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic       prev_q;

    //------------------------------------------------------------------
    // Two-stage synchronisers
    //------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= i_raw[g];
                    s2_q[g] <= s1_q[g];
                end
            end
        end
    endgenerate

    //------------------------------------------------------------------
    // Rising edge of the oscillator input
    //------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= s2_q[0];
        end
    end

    assign pins.lvl     = s2_q;
    assign pins.in_rise = s2_q[0] & ~prev_q;

endmodule

`default_nettype wire

// ---- sim/tmo_xtal_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module tmo_xtal_model #(
    parameter int START_NS = 400  // Shortened crystal start-up
) (
    input  wire logic i_osc_en, // Amplifier on
    input  wire logic i_ext,    // External count clock on
    output logic      o_in,     // Input pin level
    output logic      o_out     // Output pin level
);
    logic run;

    always @(i_osc_en) begin
        if (!i_osc_en) run = 1'b0;
        else run <= #(START_NS) 1'b1;
    end

    // Pin stands still unless crystal or external clock runs
    initial begin
        run = 1'b0;
        o_in = 1'b0;
        #3;
        forever #40 if (run || i_ext) o_in = ~o_in;
    end

    assign o_out = ~o_in;
endmodule

`default_nettype wire

// ---- sim/tmo_timer_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

module tmo_timer_checker
    import tmo_pkg::*;
(
    input wire logic                       I_CLOCK,
    input wire logic                       I_RESET_N,
    input wire logic                       I_PSEL,
    input wire logic                       I_PENABLE,
    input wire logic                       I_PWRITE,
    input wire logic [tmo_pkg::ADDR_W-1:0] I_PADDR,
    input wire logic [31:0]                I_PWDATA,
    input wire logic [3:0]                 I_PSTRB,
    input wire logic                       O_PREADY,
    input wire logic                       I_OSC_FAIL,
    input wire logic                       I_SLEEP_EXEC,
    input wire logic                       O_OSC_EN,
    input wire logic                       O_PIN_DIG_DIS,
    input wire logic [1:0]                 O_PIN_RD,
    input wire logic                       O_IRQ,
    input wire logic                       O_SEC_ACTIVE,
    input wire logic [2:0]                 O_PM_MODE
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);

    logic wr;
    assign wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & I_PSTRB[0];

    property p_osc_en;
        wr && I_PADDR == OFS_CTRL
        |-> ##2 O_OSC_EN == $past(I_PWDATA[CTL_OSCEN], 2);
    endproperty
    a_osc_en: assert property (p_osc_en)
        else $error("oscillator enable wrong");
    property p_osc_hold;
        O_OSC_EN && !I_PSEL && !$past(I_PSEL) |=> O_OSC_EN;
    endproperty
    a_osc_hold: assert property (p_osc_hold)
        else $error("oscillator stopped");
    property p_sec_run;
        wr && I_PADDR == OFS_OSC && I_PWDATA[1:0] == SEL_SECONDARY
        && O_PM_MODE == PM_PRI_RUN && !I_OSC_FAIL
        |-> ##[1:3] O_PM_MODE == PM_SEC_RUN;
    endproperty
    a_sec_run: assert property (p_sec_run)
        else $error("secondary run not entered");
    property p_sec_idle;
        O_PM_MODE == PM_SEC_RUN && I_SLEEP_EXEC && !I_OSC_FAIL
        |-> ##[1:2] O_PM_MODE inside {PM_SEC_IDLE, PM_SLEEP};
    endproperty
    a_sec_idle: assert property (p_sec_idle)
        else $error("sleep not taken");
    property p_fail;
        I_OSC_FAIL [*6] |-> !O_SEC_ACTIVE;
    endproperty
    a_fail: assert property (p_fail)
        else $error("active flag kept after failure");
    property p_irq_mask;
        wr && I_PADDR == OFS_IRQEN && !I_PWDATA[0] |-> ##2 !O_IRQ;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("masked interrupt raised");
    property p_pins;
        O_OSC_EN [*2] |-> O_PIN_DIG_DIS && O_PIN_RD == 2'h0;
    endproperty
    a_pins: assert property (p_pins)
        else $error("pin path not disabled");
    property p_irq_hold;
        O_IRQ && !I_PSEL && !$past(I_PSEL) |=> O_IRQ;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped");

    c_irq: cover property (O_IRQ);
    c_idle: cover property (O_PM_MODE == PM_SEC_IDLE);
    c_sleep: cover property (O_PM_MODE == PM_SLEEP);
endmodule

bind tmo_timer tmo_timer_checker u_tmo_timer_checker (
    .I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB), .O_PREADY(O_PREADY),
    .I_OSC_FAIL(I_OSC_FAIL), .I_SLEEP_EXEC(I_SLEEP_EXEC),
    .O_OSC_EN(O_OSC_EN), .O_PIN_DIG_DIS(O_PIN_DIG_DIS),
    .O_PIN_RD(O_PIN_RD), .O_IRQ(O_IRQ), .O_SEC_ACTIVE(O_SEC_ACTIVE),
    .O_PM_MODE(O_PM_MODE));

`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top import tmo_pkg::*;;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [31:0] q;
        logic        e;
    } tmo_row_s;
    logic        clk, rst_n, psel, pen, pwr, perr, pready, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        fail, slp, wake, ext, osc_en, dig_dis, irq, adc, act;
    logic        pin_in, pin_out;
    logic [1:0]  pin_rd;
    logic [2:0]  pm;
    int          mismatches, tests_run;
    int          adc_n = 0;
    tmo_row_s    rows[9] = '{
        '{OFS_COUNT, 32'hFFFF, 4'h0, 32'h0, 1'b0},
        '{OFS_CTRL, 32'h30, 4'hF, 32'h0, 1'b0},
        '{OFS_IRQEN, 32'h1, 4'hF, 32'h1, 1'b0},
        '{OFS_IRQEN, 32'h0, 4'hE, 32'h1, 1'b0},
        '{OFS_CMPA, 32'h0017_0010, 4'hF, 32'h0017_0010, 1'b0},
        '{OFS_COUNT, 32'h1234, 4'h3, 32'h1234, 1'b0},
        '{OFS_COUNT, 32'hABCD, 4'h1, 32'h12CD, 1'b0},
        '{OFS_ADC, 32'h1, 4'hF, 32'h1, 1'b0},
        '{8'h20, 32'h5, 4'hF, 32'h0, 1'b1}};

    tmo_timer u_tmo_timer (
        .I_CLOCK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(perr), .I_OSC_IN_PIN(pin_in),
        .I_OSC_OUT_PIN(pin_out), .I_OSC_FAIL(fail), .I_SLEEP_EXEC(slp),
        .I_WAKE(wake), .O_OSC_EN(osc_en), .O_PIN_DIG_DIS(dig_dis),
        .O_PIN_RD(pin_rd), .O_IRQ(irq), .O_ADC_START(adc),
        .O_SEC_ACTIVE(act), .O_PM_MODE(pm));
    tmo_xtal_model u_tmo_xtal_model (.i_osc_en(osc_en), .i_ext(ext),
        .o_in(pin_in), .o_out(pin_out));

    always #4 clk = ~clk;
    always @(posedge clk) if (adc === 1'b1) adc_n <= adc_n + 1;

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic conclude();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic stop();
        mismatches++;
        conclude();
    endtask
    // APB transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n = 0;
        @(posedge clk);
        {psel, pwr, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) stop();
        rd = prdata;
        er = perr;
        {psel, pen} <= 2'b00;
    endtask
    task automatic nx(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic pulse(input logic w);
        @(posedge clk);
        wake <= w;
        slp <= !w;
        @(posedge clk);
        wake <= 1'b0;
        slp <= 1'b0;
    endtask

    initial begin
        logic [7:0] a;
        int n, n0;
        {clk, psel, pen, pwr, paddr, pwdata, pstrb} = '0;
        {fail, slp, wake, ext, rst_n} = '0;
        mismatches = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
            apb(1'b0, rows[i].a, 32'h0, 4'h0);
            chk(rd, rows[i].q);
            chk(32'(er), 32'(rows[i].e));
        end
        apb(1'b1, OFS_COUNT, 32'hFFF8, 4'hF);
        apb(1'b1, OFS_CTRL, 32'h1, 4'hF);
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clk);
            if (++n == 300) stop();
        end
        apb(1'b0, OFS_COUNT, 32'h0, 4'h0);
        chk(32'(rd[15:1]), 32'h0);
        apb(1'b1, OFS_COUNT, 32'h8000, 4'h2);
        apb(1'b0, OFS_COUNT, 32'h0, 4'h0);
        chk(32'(rd[15:8]), 32'h80);
        apb(1'b1, OFS_IRQEN, 32'h0, 4'hF);
        nx(2);
        chk(32'(irq), 32'h0);
        apb(1'b0, OFS_FLAG, 32'h0, 4'h0);
        chk(rd, 32'h1);
        apb(1'b1, OFS_IRQEN, 32'h1, 4'hF);
        nx(2);
        chk(32'(irq), 32'h1);
        apb(1'b1, OFS_FLAG, 32'h1, 4'hF);
        apb(1'b0, OFS_FLAG, 32'h0, 4'h0);
        chk(rd, 32'h0);
        for (int u = 0; u < 3; u++) begin
            a = (u == 0) ? OFS_CMPA : OFS_CMPB;
            if (u == 2) apb(1'b1, OFS_ADC, 32'h0, 4'hF);
            apb(1'b1, OFS_COUNT, 32'h0, 4'hF);
            apb(1'b1, a, 32'h001B_0005, 4'hF);
            n0 = adc_n;
            nx(200);
            apb(1'b0, OFS_COUNT, 32'h0, 4'h0);
            chk(32'(rd[15:0] <= 16'h5), 32'h1);
            chk(32'(adc_n > n0), 32'(u == 1));
            apb(1'b1, a, 32'h0, 4'hF);
        end
        apb(1'b0, OFS_FLAG, 32'h0, 4'h0);
        chk(rd, 32'h0);
        apb(1'b1, OFS_COUNT, 32'h0, 4'hF);
        apb(1'b1, OFS_CMPA, 32'h001B_0003, 4'hF);
        ext <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h3, 4'hF);
        nx(300);
        apb(1'b0, OFS_COUNT, 32'h0, 4'h0);
        chk(32'(rd[15:0] <= 16'h3), 32'h1);
        // Unsynchronised counting as timekeeping firmware uses
        apb(1'b1, OFS_CTRL, 32'h7, 4'hF);
        nx(600);
        apb(1'b0, OFS_COUNT, 32'h0, 4'h0);
        chk(32'(rd[15:0] inside {[16'd56:16'd68]}), 32'h1);
        ext <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h8, 4'hF);
        nx(2);
        chk({osc_en, dig_dis, pin_rd}, 4'hC);
        nx(100);
        apb(1'b1, OFS_OSC, 32'h1, 4'hF);
        nx(3);
        chk({act, pm}, {1'b1, PM_SEC_RUN});
        pulse(1'b0);
        nx(2);
        chk(32'(pm), 32'(PM_SEC_IDLE));
        pulse(1'b1);
        nx(2);
        @(posedge clk);
        fail <= 1'b1;
        nx(8);
        chk({act, pm}, {1'b0, PM_PRI_RUN});
        @(posedge clk);
        fail <= 1'b0;
        nx(4);
        apb(1'b1, OFS_OSC, 32'h5, 4'hF);
        pulse(1'b0);
        nx(2);
        chk({osc_en, pm}, {1'b1, PM_SLEEP});
        pulse(1'b1);
        apb(1'b1, OFS_CTRL, 32'h0, 4'hF);
        nx(4);
        chk({osc_en, dig_dis}, 2'b00);
        chk(32'(pin_rd), 32'({pin_out, pin_in}));
        conclude();
    end
endmodule

`default_nettype wire
